/* core/wwd_pkg.sv */
package wwd_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] WWD_CTRL_OFS   = 12'h880;
   localparam logic [11:0] WWD_CLR_OFS    = 12'h884;
   localparam logic [11:0] WWD_SET_OFS    = 12'h888;
   localparam logic [11:0] WWD_INV_OFS    = 12'h88c;
   localparam logic [11:0] WWD_STAT_OFS   = 12'h890;
   localparam logic [11:0] WWD_MASK_OFS   = 12'h894;
   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   localparam int          WWD_ON_BIT     = 15;
   localparam int          WWD_RDIV_LSB   = 8;
   localparam int          WWD_CSEL_LSB   = 6;
   localparam int          WWD_SDIV_LSB   = 1;
   localparam int          WWD_WIN_BIT    = 0;
   localparam int          WWD_KEY_LSB    = 16;
   localparam logic [15:0] WWD_CLEAR_KEY  = 16'h5743;
   localparam logic [3:0]  WWD_KEY_STRB   = 4'hc;
   localparam logic        WWD_ON_RST     = 1'h0;
   // ------------------------------------------------------------
   // Status and mask fields
   // ------------------------------------------------------------
   localparam int          WWD_EV_W       = 3;
   localparam int          WWD_EV_RESET   = 0;
   localparam int          WWD_EV_WAKE    = 1;
   localparam int          WWD_EV_WINVIO  = 2;
   localparam logic [2:0]  WWD_EV_RST     = 3'h0;
   localparam logic [1:0]  WWD_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  WWD_RESP_SLV   = 2'h2;
endpackage : wwd_pkg

/* core/wwd_post_cnt.sv */
`timescale 1ns/100ps
module wwd_post_cnt
   import wwd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        run,
   input  wire logic        tick,
   input  wire logic        restart,
   input  wire logic [4:0]  div,
   output logic [31:0]      cnt,
   output logic             expire,
   output logic             win_open
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic [31:0] limit;

   // Period is 2^div ticks
   assign limit    = 32'((33'h1 << div) - 33'h1);
   assign expire   = run & tick & (cnt_r == limit);
   assign win_open = cnt_r >= (limit - (limit >> 2));
   assign cnt      = cnt_r;

   always_comb begin
      cnt_nxt = cnt_r;
      if (restart || !run || expire) begin
         cnt_nxt = '0;
      end else if (tick) begin
         cnt_nxt = cnt_r + 32'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   a_cnt_restart : assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> cnt_r == 32'h0) else $error("count not restarted");
endmodule : wwd_post_cnt

/* core/wwd_top.sv */
// Function
// - Software restarts the count by one 16-bit write of the clear key to the upper half.
// - An enabled watchdog that times out in Run mode requests a device reset.
// - A time-out during Sleep or Idle produces a wake-up event instead.
// - Control bit 15 runs the watchdog when set and stops it when clear.
// - The software enable counts only while the configuration enable is zero.
// - Each reset loads the run postscale copy from its configuration bits; read-only.
// - Each reset loads the run clock select copy from its configuration bits; read-only.
// - Each reset loads the sleep postscale copy from its configuration bits; read-only.
// - Each reset sets window enable to the inverse of window disable; writable later.
// - Window enable set selects windowed mode, clear selects non-windowed mode.
// - Run and Sleep/Idle use separate periods, each from its own postscale value.
// - Sleep/Idle counts low-power RC ticks; Run counts the selected run clock.
// - Clear, set and invert aliases at +0x4, +0x8 and +0xc act on bits written as one.
`timescale 1ns/100ps
module wwd_top
   import wwd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        config_watchdog_enable,
   input  wire logic [4:0]  run_postscale_config,
   input  wire logic [1:0]  run_clock_config,
   input  wire logic [4:0]  sleep_postscale_config,
   input  wire logic        window_disable_config,
   input  wire logic [3:0]  run_clk_tick,
   input  wire logic        low_power_rc_osc,
   input  wire logic        sleep_mode,
   input  wire logic        idle_mode,
   output logic             device_reset_req,
   output logic             wake_event,
   output logic             irq
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [11:0]       aw_addr_r, aw_addr_nxt;
   logic [31:0]       w_data_r, w_data_nxt;
   logic [3:0]        w_strb_r, w_strb_nxt;
   logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              on_r, on_nxt, win_r, win_nxt;
   logic [4:0]        rdiv_r, rdiv_nxt, sdiv_r, sdiv_nxt;
   logic [1:0]        csel_r, csel_nxt;
   logic [WWD_EV_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic              rst_req_r, rst_req_nxt, wake_r, wake_nxt;
   logic              do_wr, key_ok, wd_run, low_pwr, tick, expire, win_open;
   logic [4:0]        div;
   logic [31:0]       cnt, ctrl_rd;
   logic [WWD_EV_W-1:0] ev;

   // ------------------------------------------------------------
   // Watchdog core
   // ------------------------------------------------------------
   assign do_wr   = aw_hold_r & w_hold_r & ~bvalid_r;
   assign key_ok  = do_wr && aw_addr_r == WWD_CTRL_OFS && w_strb_r == WWD_KEY_STRB
                    && w_data_r[31:WWD_KEY_LSB] == WWD_CLEAR_KEY;
   assign wd_run  = config_watchdog_enable | on_r;
   assign low_pwr = sleep_mode | idle_mode;
   assign tick    = low_pwr ? low_power_rc_osc : run_clk_tick[csel_r];
   assign div     = low_pwr ? sdiv_r : rdiv_r;

   wwd_post_cnt wwd_post_cnt_inst (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (wd_run),
      .tick     (tick),
      .restart  (key_ok),
      .div      (div),
      .cnt      (cnt),
      .expire   (expire),
      .win_open (win_open)
   );

   // Early key in windowed mode is a violation
   always_comb begin
      ev                = '0;
      ev[WWD_EV_RESET]  = expire & ~low_pwr;
      ev[WWD_EV_WAKE]   = expire & low_pwr;
      ev[WWD_EV_WINVIO] = key_ok & wd_run & win_r & ~win_open;
      rst_req_nxt       = ev[WWD_EV_RESET] | ev[WWD_EV_WINVIO];
      wake_nxt          = ev[WWD_EV_WAKE];
   end

   assign ctrl_rd = {16'h0, on_r, 2'h0, rdiv_r, csel_r, sdiv_r, win_r};

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_comb begin
      on_nxt   = on_r;
      win_nxt  = win_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      rdiv_nxt = rdiv_r;
      csel_nxt = csel_r;
      sdiv_nxt = sdiv_r;
      if (do_wr) begin
         case (aw_addr_r)
            WWD_CTRL_OFS: begin
               if (w_strb_r[1]) on_nxt = w_data_r[WWD_ON_BIT];
               if (w_strb_r[0]) win_nxt = w_data_r[WWD_WIN_BIT];
            end
            WWD_CLR_OFS: begin
               if (w_strb_r[1]) on_nxt = on_r & ~w_data_r[WWD_ON_BIT];
               if (w_strb_r[0]) win_nxt = win_r & ~w_data_r[WWD_WIN_BIT];
            end
            WWD_SET_OFS: begin
               if (w_strb_r[1]) on_nxt = on_r | w_data_r[WWD_ON_BIT];
               if (w_strb_r[0]) win_nxt = win_r | w_data_r[WWD_WIN_BIT];
            end
            WWD_INV_OFS: begin
               if (w_strb_r[1]) on_nxt = on_r ^ w_data_r[WWD_ON_BIT];
               if (w_strb_r[0]) win_nxt = win_r ^ w_data_r[WWD_WIN_BIT];
            end
            WWD_STAT_OFS: begin
               if (w_strb_r[0]) stat_nxt = stat_r & ~w_data_r[WWD_EV_W-1:0];
            end
            WWD_MASK_OFS: begin
               if (w_strb_r[0]) mask_nxt = w_data_r[WWD_EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Events win over a clear in the same cycle
      stat_nxt = stat_nxt | ev;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_r      <= WWD_ON_RST;
         win_r     <= ~window_disable_config;
         rdiv_r    <= run_postscale_config;
         csel_r    <= run_clock_config;
         sdiv_r    <= sleep_postscale_config;
         stat_r    <= WWD_EV_RST;
         mask_r    <= WWD_EV_RST;
         rst_req_r <= 1'b0;
         wake_r    <= 1'b0;
      end else begin
         on_r      <= on_nxt;
         win_r     <= win_nxt;
         rdiv_r    <= rdiv_nxt;
         csel_r    <= csel_nxt;
         sdiv_r    <= sdiv_nxt;
         stat_r    <= stat_nxt;
         mask_r    <= mask_nxt;
         rst_req_r <= rst_req_nxt;
         wake_r    <= wake_nxt;
      end
   end

   assign device_reset_req = rst_req_r;
   assign wake_event       = wake_r;
   assign irq              = |(stat_r & mask_r);

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt  = w_hold_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (s_axi_awvalid && !aw_hold_r) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && !w_hold_r) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = (aw_addr_r inside {WWD_CTRL_OFS, WWD_CLR_OFS, WWD_SET_OFS,
                        WWD_INV_OFS, WWD_STAT_OFS, WWD_MASK_OFS}) ? WWD_RESP_OKAY
                        : WWD_RESP_SLV;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = WWD_RESP_OKAY;
         case ({s_axi_araddr[11:2], 2'b00})
            WWD_CTRL_OFS: rdata_nxt = ctrl_rd;
            WWD_CLR_OFS, WWD_SET_OFS, WWD_INV_OFS: rdata_nxt = 32'h0;
            WWD_STAT_OFS: rdata_nxt = {29'h0, stat_r};
            WWD_MASK_OFS: rdata_nxt = {29'h0, mask_r};
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = WWD_RESP_SLV;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= 12'h0;
         w_hold_r  <= 1'b0;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= WWD_RESP_OKAY;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= WWD_RESP_OKAY;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r  <= w_hold_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   assign s_axi_awready = ~aw_hold_r;
   assign s_axi_wready  = ~w_hold_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_key_write;
      do_wr && aw_addr_r == WWD_CTRL_OFS && w_strb_r == WWD_KEY_STRB
      && w_data_r[31:16] == WWD_CLEAR_KEY;
   endsequence

   sequence s_expire_run;
      expire && !low_pwr;
   endsequence

   a_key_restart : assert property (@(posedge aclk) disable iff (!aresetn)
      s_key_write |=> cnt == 32'h0) else $error("key did not restart");
   a_bad_key : assert property (@(posedge aclk) disable iff (!aresetn)
      (do_wr && aw_addr_r == WWD_CTRL_OFS && wd_run && !tick
      && (w_strb_r != WWD_KEY_STRB || w_data_r[31:16] != WWD_CLEAR_KEY))
      |=> cnt == $past(cnt)) else $error("bad key moved count");
   a_timeout_reset : assert property (@(posedge aclk) disable iff (!aresetn)
      s_expire_run |=> device_reset_req && !wake_event) else $error("no reset");
   a_sleep_wake : assert property (@(posedge aclk) disable iff (!aresetn)
      (expire && low_pwr) |=> wake_event && !device_reset_req) else $error("no wake");
   a_on_stop : assert property (@(posedge aclk) disable iff (!aresetn)
      (!wd_run)[*2] |-> cnt == 32'h0 && !expire) else $error("stopped count moved");
   a_cfg_enable : assert property (@(posedge aclk) disable iff (!aresetn)
      (config_watchdog_enable && tick && !key_ok && !expire) |=> cnt == $past(cnt) + 32'h1)
      else $error("config enable ignored");
   a_shadow_load : assert property (@(posedge aclk)
      !aresetn |=> rdiv_r == $past(run_postscale_config)
      && csel_r == $past(run_clock_config) && sdiv_r == $past(sleep_postscale_config))
      else $error("shadow copy not loaded");
   a_shadow_ro : assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> $stable(rdiv_r) && $stable(csel_r) && $stable(sdiv_r))
      else $error("shadow copy written");
   a_win_init : assert property (@(posedge aclk)
      !aresetn |=> win_r == !$past(window_disable_config)) else $error("window init");
   a_window_viol : assert property (@(posedge aclk) disable iff (!aresetn)
      (s_key_write ##0 (wd_run && win_r && !win_open)) |=> device_reset_req
      ##1 stat_r[WWD_EV_WINVIO]) else $error("early key not caught");
   a_alias_set : assert property (@(posedge aclk) disable iff (!aresetn)
      (do_wr && aw_addr_r == WWD_SET_OFS && w_strb_r[1] && w_data_r[WWD_ON_BIT])
      |=> on_r) else $error("set alias failed");
   a_run_div : assert property (@(posedge aclk) disable iff (!aresetn)
      (!low_pwr && wd_run && tick) |-> expire == (cnt == (32'h1 << rdiv_r) - 32'h1))
      else $error("wrong divider");
   a_lp_tick : assert property (@(posedge aclk) disable iff (!aresetn)
      (low_pwr && wd_run && !low_power_rc_osc && !key_ok) |=> cnt == $past(cnt))
      else $error("lp clock");
endmodule : wwd_top

/* verification/wwd_top_bench.sv */
`timescale 1ns/100ps
module wwd_top_bench
   import wwd_pkg::*;
;
   logic        aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        config_watchdog_enable, window_disable_config;
   logic [4:0]  run_postscale_config, sleep_postscale_config;
   logic [1:0]  run_clock_config;
   logic [3:0]  run_clk_tick;
   logic        low_power_rc_osc, sleep_mode, idle_mode;
   logic        device_reset_req, wake_event, irq;
   logic [31:0] rd_q;
   logic [1:0]  resp_q;
   int          fail_count, n_compared, cyc, rst_seen, wake_seen, rst_base, wake_base;

   wwd_top wwd_top_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .config_watchdog_enable(config_watchdog_enable),
      .run_postscale_config(run_postscale_config), .run_clock_config(run_clock_config),
      .sleep_postscale_config(sleep_postscale_config),
      .window_disable_config(window_disable_config), .run_clk_tick(run_clk_tick),
      .low_power_rc_osc(low_power_rc_osc), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
      .device_reset_req(device_reset_req), .wake_event(wake_event), .irq(irq)
   );

   // ------------------------------------------------------------
   // Clock, pulse counting, hang guard
   // ------------------------------------------------------------
   initial aclk = 1'b0;
   always #50 aclk = ~aclk;

   always @(posedge aclk) begin
      if (device_reset_req === 1'b1) rst_seen++;
      if (wake_event === 1'b1) wake_seen++;
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_pulses(input int er, input int ew);
      chk_word(32'(rst_seen - rst_base), 32'(er));
      chk_word(32'(wake_seen - wake_base), 32'(ew));
      rst_base = rst_seen;
      wake_base = wake_seen;
   endtask : chk_pulses

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            resp_q = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            rd_q = s_axi_rdata;
            resp_q = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd

   task automatic key();
      wr(WWD_CTRL_OFS, {WWD_CLEAR_KEY, 16'h0000}, WWD_KEY_STRB);
   endtask : key

   task automatic ticks(input logic [3:0] rt, input logic lp, input int n);
      repeat (n) begin
         @(posedge aclk);
         run_clk_tick <= rt;
         low_power_rc_osc <= lp;
      end
      @(posedge aclk);
      run_clk_tick <= 4'h0;
      low_power_rc_osc <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : ticks

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset

   task automatic wrap_up();
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {run_clk_tick, low_power_rc_osc, sleep_mode, idle_mode} = '0;
      config_watchdog_enable = 1'b0;
      run_postscale_config = 5'h03;
      run_clock_config = 2'h2;
      sleep_postscale_config = 5'h02;
      window_disable_config = 1'b1;
      {fail_count, n_compared, cyc, rst_seen, wake_seen, rst_base, wake_base} = '0;
      do_reset();
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_0384);
      chk_word(32'(resp_q), 32'(WWD_RESP_OKAY));
      wr(WWD_CTRL_OFS, 32'h0000_ffff, 4'h3);
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_8385);
      wr(WWD_CLR_OFS, 32'h0000_8001, 4'hf);
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_0384);
      wr(WWD_SET_OFS, 32'h0000_8001, 4'hf);
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_8385);
      wr(WWD_INV_OFS, 32'h0000_8001, 4'hf);
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_0384);
      wr(WWD_INV_OFS, 32'h0000_8000, 4'hf);
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_8384);
      rd(WWD_CLR_OFS);
      chk_word(rd_q, 32'h0000_0000);
      rd(12'h8a0);
      chk_word({rd_q[29:0], resp_q}, {30'h0, WWD_RESP_SLV});
      wr(12'h8a0, 32'hffff_ffff, 4'hf);
      chk_word(32'(resp_q), 32'(WWD_RESP_SLV));
      // Run mode: only the selected source counts, key restarts
      ticks(4'hb, 1'b0, 20);
      chk_pulses(0, 0);
      ticks(4'h4, 1'b0, 6);
      key();
      chk_word(32'(resp_q), 32'(WWD_RESP_OKAY));
      ticks(4'h4, 1'b0, 6);
      key();
      ticks(4'h4, 1'b0, 6);
      chk_pulses(0, 0);
      wr(WWD_CTRL_OFS, 32'h5742_8000, 4'hc);
      wr(WWD_CTRL_OFS, 32'h5743_8000, 4'hf);
      ticks(4'h4, 1'b0, 4);
      chk_pulses(1, 0);
      rd(WWD_STAT_OFS);
      chk_word(rd_q, 32'h0000_0001);
      chk_bit(irq, 1'b0);
      wr(WWD_MASK_OFS, 32'h0000_0007, 4'hf);
      chk_bit(irq, 1'b1);
      wr(WWD_STAT_OFS, 32'h0000_0001, 4'hf);
      chk_bit(irq, 1'b0);
      // Low-power modes count only the RC ticks, with the sleep period
      key();
      sleep_mode <= 1'b1;
      ticks(4'h4, 1'b0, 10);
      ticks(4'h0, 1'b1, 3);
      chk_pulses(0, 0);
      ticks(4'h0, 1'b1, 2);
      chk_pulses(0, 1);
      sleep_mode <= 1'b0;
      idle_mode <= 1'b1;
      key();
      ticks(4'h0, 1'b1, 5);
      chk_pulses(0, 1);
      chk_bit(irq, 1'b1);
      rd(WWD_STAT_OFS);
      chk_word(rd_q, 32'h0000_0002);
      wr(WWD_STAT_OFS, 32'h0000_0007, 4'hf);
      idle_mode <= 1'b0;
      // Windowed mode: early key is a violation, late key is fine
      wr(WWD_SET_OFS, 32'h0000_0001, 4'hf);
      key();
      repeat (3) @(posedge aclk);
      chk_pulses(1, 0);
      rd(WWD_STAT_OFS);
      chk_word(rd_q, 32'h0000_0004);
      wr(WWD_STAT_OFS, 32'h0000_0007, 4'hf);
      ticks(4'h4, 1'b0, 6);
      key();
      repeat (3) @(posedge aclk);
      chk_pulses(0, 0);
      // Software enable versus configuration enable
      wr(WWD_CLR_OFS, 32'h0000_8001, 4'hf);
      ticks(4'h4, 1'b0, 10);
      chk_pulses(0, 0);
      config_watchdog_enable <= 1'b1;
      ticks(4'h4, 1'b0, 10);
      chk_pulses(1, 0);
      config_watchdog_enable <= 1'b0;
      // Second reset reloads the copies
      run_postscale_config <= 5'h1c;
      run_clock_config <= 2'h1;
      sleep_postscale_config <= 5'h11;
      window_disable_config <= 1'b0;
      do_reset();
      rd(WWD_CTRL_OFS);
      chk_word(rd_q, 32'h0000_1c63);
      rd(WWD_MASK_OFS);
      chk_word(rd_q, 32'h0000_0000);
      wrap_up();
   end
endmodule : wwd_top_bench
